//--- rdc_top.sv
// Purpose: drift calibration, run control, minute/second count and clock pin select
// Assumes: CLOCK_I 10 MHz; OSC_I is an asynchronous oscillator pin; ALARM_PULSE_I is
//    from alarm logic on CLOCK_I
// Notes: calibration and pad settings live on POR_N_I only, time keeping on RST_N_I
// Overview of operation
// (RULE_01) the largest positive calibration value adds 508 oscillator pulses each minute.
// (RULE_02) value 1 adds 4 pulses per minute and each further step adds 4 more.
// (RULE_03) value all ones removes 4 pulses per minute.
// (RULE_04) the most negative value removes 512 pulses, the field being two's complement.
// (RULE_05) a zero value applies no correction.
// (RULE_06) the calibration register is reset only by power-on reset.
// (RULE_07) run-enable changes only while the write-unlock bit is 1.
// (RULE_08) the half-second status is read-only and clears on a write to the seconds byte.
// (RULE_09) half-second status reads 1 in the second half of each second, else 0.
// (RULE_10) source select 1 puts the seconds clock on the pin, 0 the alarm pulse.
// (RULE_11) the pin is driven only while the pin output enable bit is set.
// (RULE_12) bits 15 to 2 of the pad register read zero.
// (RULE_13) source select and input level select clear on power-on reset.
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/100ps
module rdc_top #(
   parameter int OSC_HZ = rdc_pkg::OSC_HZ
) (
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire logic POR_N_I,
   input wire logic [3:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   input wire logic OSC_I,
   input wire logic ALARM_PULSE_I,
   output logic CLOCK_PIN_O,
   output logic CLOCK_PIN_OE_O,
   output logic PARALLEL_PORT_INPUT_LEVEL_SELECT_O
);
   // power-on domain state
   typedef struct packed {
      logic [rdc_pkg::CAL_W-1:0] cal;
      logic pin_oe;
      logic unlock;
      logic run;
      logic src_sel;
      logic par_level;
   } rdc_por_s;

   // system domain state
   typedef struct packed {
      logic ack;
      logic wreq;
      logic [31:0] rdata;
      logic [rdc_pkg::TIME_W-1:0] sec;
      logic [rdc_pkg::TIME_W-1:0] min;
      logic osc_s1;
      logic osc_s2;
      logic osc_s3;
      logic pin;
      logic pin_oe;
   } rdc_sys_s;

   // waitrequest sits high through reset, so its flop resets to one
   localparam rdc_sys_s SYS_RESET = '{wreq: 1'b1, default: '0};

   logic [1:0] rst_sync;
   logic [1:0] por_sync;
   logic rst_n;
   logic por_n;
   rdc_por_s por;
   rdc_por_s next_por;
   rdc_sys_s sys;
   rdc_sys_s next_sys;
   logic req;
   logic accept;
   logic wr;
   logic hit_cal;
   logic hit_pad;
   logic hit_time;
   logic [15:0] cal_word;
   logic [15:0] pad_word;
   logic [15:0] time_word;

   rdc_cal_if cal_if ();

   rdc_prescaler #(
      .OSC_HZ(OSC_HZ)
   ) u_pre (
      .clk_i(CLOCK_I),
      .rst_n_i(rst_n),
      .cal_if(cal_if)
   );

   // reset release through two flops, assertion stays asynchronous
   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end

   always_ff @(posedge CLOCK_I or negedge POR_N_I) begin
      if (!POR_N_I) begin
         por_sync <= 2'h0;
      end else begin
         por_sync <= {por_sync[0], 1'b1};
      end
   end

   assign rst_n = rst_sync[1];
   assign por_n = por_sync[1];

   // bus decode; one wait cycle, then a single answer cycle
   assign req = AVS_READ_I | AVS_WRITE_I;
   // nothing is taken while the system side is still held in reset
   assign accept = req && !sys.ack && rst_n;
   assign wr = accept && AVS_WRITE_I;
   assign hit_cal = AVS_ADDRESS_I == rdc_pkg::OFF_CAL_CFG;
   assign hit_pad = AVS_ADDRESS_I == rdc_pkg::OFF_PAD_CFG;
   assign hit_time = AVS_ADDRESS_I == rdc_pkg::OFF_MIN_SEC;

   always_comb begin
      cal_word = '0;
      cal_word[rdc_pkg::CAL_LSB +: rdc_pkg::CAL_W] = por.cal;
      cal_word[rdc_pkg::BIT_PIN_OE] = por.pin_oe;
      // RULE_09 live half-second status
      cal_word[rdc_pkg::BIT_HALF_SEC] = cal_if.half_sec;
      cal_word[rdc_pkg::BIT_UNLOCK] = por.unlock;
      cal_word[rdc_pkg::BIT_RUN] = por.run;
      // RULE_12 unused pad bits zero
      pad_word = '0;
      pad_word[rdc_pkg::BIT_SRC_SEL] = por.src_sel;
      pad_word[rdc_pkg::BIT_PAR_LEVEL] = por.par_level;
      time_word = '0;
      time_word[rdc_pkg::SEC_LSB +: rdc_pkg::TIME_W] = sys.sec;
      time_word[rdc_pkg::MIN_LSB +: rdc_pkg::TIME_W] = sys.min;
   end

   // power-on domain registers
   always_comb begin
      next_por = por;
      if (wr && hit_cal) begin
         if (AVS_BYTEENABLE_I[0]) begin
            next_por.cal = AVS_WRITEDATA_I[rdc_pkg::CAL_LSB +: rdc_pkg::CAL_W];
         end
         if (AVS_BYTEENABLE_I[1]) begin
            next_por.pin_oe = AVS_WRITEDATA_I[rdc_pkg::BIT_PIN_OE];
            next_por.unlock = AVS_WRITEDATA_I[rdc_pkg::BIT_UNLOCK];
            // RULE_07 run-enable guarded by unlock
            if (por.unlock) begin
               next_por.run = AVS_WRITEDATA_I[rdc_pkg::BIT_RUN];
            end
         end
      end
      if (wr && hit_pad && AVS_BYTEENABLE_I[0]) begin
         next_por.src_sel = AVS_WRITEDATA_I[rdc_pkg::BIT_SRC_SEL];
         next_por.par_level = AVS_WRITEDATA_I[rdc_pkg::BIT_PAR_LEVEL];
      end
   end

   // RULE_06 RULE_13 power-on reset only
   always_ff @(posedge CLOCK_I or negedge por_n) begin
      if (!por_n) begin
         por <= '0;
      end else begin
         por <= next_por;
      end
   end

   // system domain: bus answer, oscillator sync, time count, pin
   always_comb begin
      next_sys = sys;
      next_sys.ack = accept;
      next_sys.wreq = !accept;
      // the first oscillator flop feeds only the second
      next_sys.osc_s1 = OSC_I;
      next_sys.osc_s2 = sys.osc_s1;
      next_sys.osc_s3 = sys.osc_s2;
      if (accept && AVS_READ_I) begin
         if (hit_cal) begin
            next_sys.rdata = {16'h0000, cal_word};
         end else if (hit_pad) begin
            next_sys.rdata = {16'h0000, pad_word};
         end else if (hit_time) begin
            next_sys.rdata = {16'h0000, time_word};
         end else begin
            next_sys.rdata = rdc_pkg::UNMAPPED_READ;
         end
      end
      if (cal_if.sec_tick) begin
         if (sys.sec >= rdc_pkg::LAST_UNIT) begin
            next_sys.sec = '0;
            if (sys.min >= rdc_pkg::LAST_UNIT) begin
               next_sys.min = '0;
            end else begin
               next_sys.min = sys.min + 6'h01;
            end
         end else begin
            next_sys.sec = sys.sec + 6'h01;
         end
      end
      if (wr && hit_time) begin
         if (AVS_BYTEENABLE_I[0]) begin
            next_sys.sec = AVS_WRITEDATA_I[rdc_pkg::SEC_LSB +: rdc_pkg::TIME_W];
         end
         if (AVS_BYTEENABLE_I[1]) begin
            next_sys.min = AVS_WRITEDATA_I[rdc_pkg::MIN_LSB +: rdc_pkg::TIME_W];
         end
      end
      // RULE_10 pin source select
      next_sys.pin = por.src_sel ? cal_if.half_sec : ALARM_PULSE_I;
      // RULE_11 pin driven only when enabled
      next_sys.pin_oe = por.pin_oe;
      if (!por.pin_oe) begin
         next_sys.pin = 1'b0;
      end
   end

   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         sys <= SYS_RESET;
      end else begin
         sys <= next_sys;
      end
   end

   always_comb begin
      cal_if.osc_edge = sys.osc_s2 && !sys.osc_s3;
      cal_if.run = por.run;
      cal_if.cal = por.cal;
      // RULE_01 correction applied once per minute
      cal_if.apply = cal_if.sec_tick && sys.sec >= rdc_pkg::LAST_UNIT;
      // RULE_08 seconds byte write clears half-second
      cal_if.clear = wr && hit_time && AVS_BYTEENABLE_I[0];
   end

   assign AVS_READDATA_O = sys.rdata;
   assign AVS_WAITREQUEST_O = sys.wreq;
   assign CLOCK_PIN_O = sys.pin;
   assign CLOCK_PIN_OE_O = sys.pin_oe;
   assign PARALLEL_PORT_INPUT_LEVEL_SELECT_O = por.par_level;
endmodule

//--- rdc_pkg.sv
// Purpose: shared constants for the clock drift calibration and pin select block
// Assumes: 32-bit Avalon-MM register words, byte addresses
// Notes: offsets are word aligned; fields are bit positions inside a word
package rdc_pkg;
   // register byte addresses
   localparam logic [3:0] OFF_CAL_CFG = 4'h0;
   localparam logic [3:0] OFF_PAD_CFG = 4'h4;
   localparam logic [3:0] OFF_MIN_SEC = 4'h8;
   // rtc_calibration_config fields
   localparam int CAL_LSB = 0;
   localparam int CAL_W = 8;
   localparam int BIT_PIN_OE = 10;
   localparam int BIT_HALF_SEC = 11;
   localparam int BIT_UNLOCK = 13;
   localparam int BIT_RUN = 15;
   // pad_config fields
   localparam int BIT_PAR_LEVEL = 0;
   localparam int BIT_SRC_SEL = 1;
   // minute_second_value fields
   localparam int SEC_LSB = 0;
   localparam int MIN_LSB = 8;
   localparam int TIME_W = 6;
   localparam logic [5:0] LAST_UNIT = 6'h3b;
   // oscillator, correction and unmapped read value
   localparam int OSC_HZ = 32768;
   localparam int CNT_W = 16;
   localparam int STEP_PULSES = 4;
   localparam int PEND_W = 10;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

//--- rdc_cal_if.sv
// Purpose: carries control and status between register file and prescaler
// Assumes: both ends on one clock
// Notes: plain wires, no clocking
`timescale 1ns/100ps
interface rdc_cal_if;
   logic osc_edge;
   logic run;
   logic [rdc_pkg::CAL_W-1:0] cal;
   logic apply;
   logic clear;
   logic sec_tick;
   logic half_sec;
   modport ctrl (output osc_edge, output run, output cal, output apply, output clear,
                 input sec_tick, input half_sec);
   modport pre (input osc_edge, input run, input cal, input apply, input clear,
                output sec_tick, output half_sec);
endinterface

//--- rdc_prescaler.sv
// Purpose: divides the oscillator to seconds and applies the per-minute drift correction
// Assumes: osc_edge is a one-cycle pulse per oscillator period, already synchronised
// Notes: extra pulses count double, removed pulses are swallowed, one per oscillator edge
`timescale 1ns/100ps
module rdc_prescaler #(
   parameter int OSC_HZ = rdc_pkg::OSC_HZ
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   rdc_cal_if.pre cal_if
);
   localparam logic [rdc_pkg::CNT_W:0] WRAP = (rdc_pkg::CNT_W+1)'(OSC_HZ);
   localparam logic [rdc_pkg::CNT_W-1:0] HALF = rdc_pkg::CNT_W'(OSC_HZ / 2);

   typedef struct packed {
      logic [rdc_pkg::CNT_W-1:0] cnt;
      logic [rdc_pkg::PEND_W-1:0] pending;
      logic neg;
      logic tick;
      logic half;
   } rdc_pre_s;

   rdc_pre_s state;
   rdc_pre_s next_state;
   logic [rdc_pkg::CNT_W:0] sum;
   logic [rdc_pkg::CAL_W-1:0] mag;

   always_comb begin
      next_state = state;
      next_state.tick = 1'b0;
      sum = {1'b0, state.cnt};
      // RULE_04 two's complement magnitude
      mag = cal_if.cal[rdc_pkg::CAL_W-1] ? (~cal_if.cal + 8'h01) : cal_if.cal;
      if (cal_if.run && cal_if.osc_edge) begin
         if (state.pending != '0) begin
            next_state.pending = state.pending - 10'h001;
            // RULE_01 extra pulse counts double
            if (!state.neg) begin
               sum = {1'b0, state.cnt} + 17'h00002;
            end
         end else begin
            sum = {1'b0, state.cnt} + 17'h00001;
         end
         if (sum >= WRAP) begin
            sum = sum - WRAP;
            next_state.tick = 1'b1;
         end
         next_state.cnt = sum[rdc_pkg::CNT_W-1:0];
      end
      // RULE_02 RULE_03 RULE_05 four pulses per step, none at zero
      if (cal_if.apply) begin
         next_state.neg = cal_if.cal[rdc_pkg::CAL_W-1];
         next_state.pending = (rdc_pkg::PEND_W)'({2'b00, mag} * rdc_pkg::STEP_PULSES);
      end
      // RULE_08 restart the second
      if (cal_if.clear) begin
         next_state.cnt = '0;
         next_state.tick = 1'b0;
      end
      // RULE_09 second half of the second
      next_state.half = next_state.cnt >= HALF;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign cal_if.sec_tick = state.tick;
   assign cal_if.half_sec = state.half;
endmodule

//--- rdc_top_props.sv
// Purpose: port checks for rdc_top
// Assumes: bound to every rdc_top
// Notes: a_oe_rise skips a few cycles after a system reset release, a_lvl_hold after a power-on release
`timescale 1ns/100ps
module rdc_top_props (
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire logic POR_N_I,
   input wire logic [3:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [31:0] AVS_READDATA_O,
   input wire logic AVS_WAITREQUEST_O,
   input wire logic CLOCK_PIN_O,
   input wire logic CLOCK_PIN_OE_O,
   input wire logic PARALLEL_PORT_INPUT_LEVEL_SELECT_O
);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I || !POR_N_I);
   wire logic ans = AVS_READ_I && !AVS_WAITREQUEST_O;
   wire logic pad_wr = AVS_WRITE_I && AVS_ADDRESS_I == rdc_pkg::OFF_PAD_CFG;
   property p_wait_one;
      !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("waitrequest low too long");
   property p_answer;
      (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |-> ##[1:2] !AVS_WAITREQUEST_O;
   endproperty
   a_answer: assert property (p_answer)
      else $error("request not answered");
   property p_pad_read;
      ans && AVS_ADDRESS_I == rdc_pkg::OFF_PAD_CFG |-> AVS_READDATA_O[31:2] == 30'h0;
   endproperty
   a_pad_read: assert property (p_pad_read)
      else $error("pad upper bits not zero");
   property p_gap_read;
      ans && AVS_ADDRESS_I == 4'hc |-> AVS_READDATA_O == rdc_pkg::UNMAPPED_READ;
   endproperty
   a_gap_read: assert property (p_gap_read)
      else $error("unmapped read not zero");
   property p_pin_off;
      !CLOCK_PIN_OE_O |-> !CLOCK_PIN_O;
   endproperty
   a_pin_off: assert property (p_pin_off)
      else $error("pin high while not enabled");
   // leaving a system reset may raise the enable from the kept setting
   property p_oe_rise;
      $rose(CLOCK_PIN_OE_O) && $past(RST_N_I, 5) |-> $past(AVS_WRITE_I
         && AVS_WRITEDATA_I[rdc_pkg::BIT_PIN_OE] && AVS_ADDRESS_I == rdc_pkg::OFF_CAL_CFG);
   endproperty
   a_oe_rise: assert property (p_oe_rise)
      else $error("pin enable rose without write");
   property p_por_clear;
      disable iff (!RST_N_I) !POR_N_I [*2] |-> !CLOCK_PIN_OE_O
         && !PARALLEL_PORT_INPUT_LEVEL_SELECT_O;
   endproperty
   a_por_clear: assert property (p_por_clear)
      else $error("config not cleared by power-on");
   // checked through system resets too: only power-on may touch the setting
   property p_lvl_hold;
      disable iff (!POR_N_I) $past(POR_N_I, 4) && !$past(pad_wr)
         |-> $stable(PARALLEL_PORT_INPUT_LEVEL_SELECT_O);
   endproperty
   a_lvl_hold: assert property (p_lvl_hold)
      else $error("level select changed without write");
endmodule
bind rdc_top rdc_top_props i_rdc_top_props (.*);

//--- rdc_top_tb.sv
// Purpose: self-checking bench for rdc_top
// Assumes: 16 oscillator edges a second
// Notes: oscillator edges are slow so each is seen once
`timescale 1ns/100ps
module rdc_top_tb;
   localparam int HZ = 16;
   localparam logic [3:0] CAL = rdc_pkg::OFF_CAL_CFG;
   localparam logic [3:0] PAD = rdc_pkg::OFF_PAD_CFG;
   localparam logic [3:0] MS = rdc_pkg::OFF_MIN_SEC;
   localparam logic [31:0] ALL = 32'hffff_ffff;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic por_n = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic osc = 1'b0;
   logic alarm = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdat;
   logic [31:0] q;
   logic wq, pin, oe, lvl;
   int n_fail = 0;
   int cmp_count = 0;
   always #50 clk = ~clk;
   rdc_top #(.OSC_HZ(HZ)) i_rdc_top (.CLOCK_I(clk), .RST_N_I(rst_n), .POR_N_I(por_n),
      .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
      .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wq),
      .OSC_I(osc), .ALARM_PULSE_I(alarm), .CLOCK_PIN_O(pin), .CLOCK_PIN_OE_O(oe),
      .PARALLEL_PORT_INPUT_LEVEL_SELECT_O(lvl));
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   // request held until the edge that sees waitrequest low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      wr <= w;
      rd <= !w;
      adr <= a;
      wd <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (wq === 1'b0) break;
      end
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      if (i == 20) begin
         n_fail++;
         wrap_up();
      end
   endtask
   task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] m, e);
      bus(1'b0, a, 32'h0);
      chk(nm, q & m, e);
   endtask
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge clk);
         osc <= 1'b1;
         repeat (4) @(posedge clk);
         osc <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
   task automatic t_regs;
      rchk("cal", CAL, 32'hffff_f7ff, 32'h0);
      rchk("pad", PAD, ALL, 32'h0);
      bus(1'b1, 4'hc, ALL);
      rchk("gap", 4'hc, ALL, rdc_pkg::UNMAPPED_READ);
      bus(1'b1, PAD, ALL);
      rchk("pad", PAD, ALL, 32'h3);
      chk("lvl", {31'h0, lvl}, 32'h1);
      bus(1'b1, PAD, 32'h0);
   endtask
   task automatic t_run;
      bus(1'b1, CAL, 32'h8000);
      rchk("run", CAL, 32'ha000, 32'h0);
      bus(1'b1, CAL, 32'h2000);
      bus(1'b1, CAL, 32'ha000);
      bus(1'b1, CAL, 32'h8000);
      bus(1'b1, CAL, 32'h2000);
      rchk("run", CAL, 32'ha000, 32'ha000);
   endtask
   task automatic t_half;
      bus(1'b1, MS, 32'h0);
      pulses(HZ / 2 - 1);
      rchk("half", CAL, 32'h800, 32'h0);
      pulses(1);
      rchk("half", CAL, 32'h800, 32'h800);
      bus(1'b1, CAL, 32'ha800);
      rchk("half", CAL, 32'h800, 32'h800);
      bus(1'b1, MS, 32'h0);
      rchk("half", CAL, 32'h800, 32'h0);
   endtask
   task automatic pin_is(input logic [1:0] e);
      repeat (3) @(posedge clk);
      chk("pin", {30'h0, oe, pin}, {30'h0, e});
   endtask
   task automatic t_pin;
      bus(1'b1, PAD, 32'h2);
      pulses(HZ / 2);
      pin_is(2'h0);
      bus(1'b1, CAL, 32'ha400);
      pin_is(2'h3);
      bus(1'b1, PAD, 32'h0);
      pin_is(2'h2);
      alarm <= 1'b1;
      pin_is(2'h3);
      alarm <= 1'b0;
   endtask
   // one minute rollover, then n edges under correction
   task automatic cal_case(input logic [7:0] c, input int n, input logic [5:0] s);
      bus(1'b1, CAL, {16'h0, 8'ha0, c});
      bus(1'b1, MS, 32'h3b);
      pulses(HZ + n);
      rchk("time", MS, 32'h3f3f, {18'h0, 6'h01, 2'h0, s});
   endtask
   task automatic t_drift;
      cal_case(8'h00, 15, 6'h00);
      cal_case(8'h01, 12, 6'h01);
      cal_case(8'h02, 8, 6'h01);
      // leftover pending would skew the next case, so all 508 are used up
      cal_case(8'h7f, 256, 6'h20);
      bus(1'b1, MS, 32'h0);
      pulses(259);
      rchk("time", MS, 32'h3f3f, 32'h1f);
      pulses(1);
      rchk("time", MS, 32'h3f3f, 32'h20);
      cal_case(8'hff, 19, 6'h00);
      cal_case(8'hff, 20, 6'h01);
      cal_case(8'h80, 527, 6'h00);
      cal_case(8'h80, 528, 6'h01);
   endtask
   task automatic t_por;
      bus(1'b1, CAL, 32'ha405);
      bus(1'b1, PAD, 32'h3);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rchk("cal", CAL, 32'hffff_f7ff, 32'ha405);
      rchk("pad", PAD, ALL, 32'h3);
      por_n <= 1'b0;
      repeat (3) @(posedge clk);
      por_n <= 1'b1;
      repeat (4) @(posedge clk);
      rchk("cal", CAL, 32'hffff_f7ff, 32'h0);
      rchk("pad", PAD, ALL, 32'h0);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_regs();
      t_run();
      t_half();
      t_pin();
      t_drift();
      t_por();
      wrap_up();
   end
endmodule
